// File: dv/dma_mode_and_request_routing_tb.sv
module dma_mode_and_request_routing_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import dmarr_pkg::*;

	// ==========================================================
	// Signals.
	// ==========================================================
	logic        clock_in = 1'b0;
	logic        rst_b_in = 1'b0;
	logic [31:0] haddr    = 32'h0;
	logic [31:0] hwdata   = 32'h0;
	logic [1:0]  htrans   = 2'h0;
	logic        hwrite   = 1'b0;
	logic        nmi      = 1'b0;
	logic        end0     = 1'b0;
	logic        end1     = 1'b0;
	logic        slow     = 1'b0;
	logic [5:0]  want     = 6'h00;
	logic [31:0] hrdata, rd;
	logic        hready, hresp, eng_rdy, req_valid, timer_sel;
	logic [5:0]  pins;
	logic [7:0]  w;
	dmarr_req_t  req;
	dmarr_wait_t wcfg;
	dmarr_chan_t c0cfg, c1cfg, e;
	int          miscompares = 0;
	int          compares    = 0;
	int          seed        = 32'hf9c8;
	int          n_ok        = 0;
	int          h;
	int          h0;

	// The clock runs at 50 MHz.
	initial forever #10 clock_in = ~clock_in;

	dmarr_src_model dmarr_src_model_i (.clock_in(clock_in), .want_in(want), .slow_in(slow),
		.pins_out(pins), .engine_ready_out(eng_rdy));

	dmarr_top #(.FIFO_DEPTH(4)) dmarr_top_i (.clock_in(clock_in), .rst_b_in(rst_b_in),
		.hsel_in(1'b1), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
		.hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
		.hreadyout_out(hready), .hresp_out(hresp), .ch0_request_pin_in(pins[0]),
		.ch1_request_pin_in(pins[1]), .serial0_tx_req_in(pins[2]),
		.serial0_rx_req_in(pins[3]), .serial1_tx_req_in(pins[4]),
		.serial1_rx_req_in(pins[5]), .nmi_in(nmi), .ch0_transfer_end_in(end0),
		.ch1_transfer_end_in(end1), .engine_ready_in(eng_rdy), .req_valid_out(req_valid),
		.req_out(req), .wait_cfg_out(wcfg), .ch0_cfg_out(c0cfg), .ch1_cfg_out(c1cfg),
		.timer_output_sel_out(timer_sel));

	// ==========================================================
	// Bus, pulse and compare tasks.
	// ==========================================================
	// One single word transfer; the wait on hready is open, the watchdog bounds it.
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
		@(posedge clock_in);
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge clock_in); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clock_in); while (hready !== 1'b1);
		rd = hrdata;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic rchk(input string what, input logic [31:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check(what, rd, exp);
	endtask

	// A one-cycle end pulse, settled three edges later.
	task automatic pulse(input logic ch1);
		@(posedge clock_in);
		if (ch1) end1 <= 1'b1; else end0 <= 1'b1;
		@(posedge clock_in);
		end0 <= 1'b0;
		end1 <= 1'b0;
		repeat (3) @(posedge clock_in);
	endtask

	// Counts cycles with a channel 1 (h) or a channel 0 (h0) request pending.
	task automatic watch(input int cycles);
		h = 0;
		h0 = 0;
		repeat (cycles) begin
			@(posedge clock_in);
			if (req_valid === 1'b1 && req.to_ch1 === 1'b1) h++;
			if (req_valid === 1'b1 && req.to_ch1 === 1'b0) h0++;
		end
	endtask

	task automatic complete_run();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Expected decode of one mode pair: step 0 hold, 1 inc, 2 dec.
	function automatic dmarr_chan_t chan_exp(input logic [1:0] dm, input logic [1:0] sm);
		chan_exp = '{src_io: sm == MODE_IO_FIXED, src_mem_cycle: sm != MODE_IO_FIXED,
			src_step: sm[1] ? STEP_HOLD : (sm[0] ? STEP_DEC : STEP_INC),
			dst_io: dm == MODE_IO_FIXED, dst_mem_cycle: dm != MODE_IO_FIXED,
			dst_step: dm[1] ? STEP_HOLD : (dm[0] ? STEP_DEC : STEP_INC),
			valid: !(dm[1] && sm[1])};
	endfunction

	// ==========================================================
	// Main sequence.
	// ==========================================================
	initial begin
		repeat (5) @(posedge clock_in);
		rst_b_in <= 1'b1;
		rchk("route reset", 32'hb4, 32'h00);
		rchk("wait reset", 32'hc8, 32'hf0);
		check("wait out reset", wcfg, 8'hf0);
		bus(1'b1, 32'h80, 32'hff);
		rchk("unmapped", 32'h80, 32'h00);
		// Every channel 0 pair; fixed with fixed must stay unusable.
		for (int i = 0; i < 16; i++) begin
			bus(1'b1, 32'hc4, {26'h0, i[3:0], 2'h0});
			repeat (3) @(posedge clock_in);
			e = chan_exp(i[3:2], i[1:0]);
			n_ok += e.valid;
			if (e.valid) check("ch0 decode", c0cfg, e);
			else check("ch0 reserved", c0cfg.valid, 1'b0);
		end
		check("usable pairs", n_ok, 12);
		// Random wait values crossed with every channel 1 mode and route code.
		for (int i = 0; i < 32; i++) begin
			w = 8'($random(seed));
			w[1:0] = i[1:0];
			bus(1'b1, 32'hb4, {29'h0, i[4:2]});
			bus(1'b1, 32'hc8, {24'h0, w});
			repeat (3) @(posedge clock_in);
			rchk("wait rw", 32'hc8, {24'h0, w});
			check("wait fields", wcfg, w);
			e = i[1] ? chan_exp({1'b0, i[0]}, 2'h3) : chan_exp(2'h3, {1'b0, i[0]});
			e.valid = !i[4];
			if (e.valid) check("ch1 decode", c1cfg, e);
			else check("ch1 reserved", c1cfg.valid, 1'b0);
		end
		bus(1'b1, 32'hb4, 32'h08);
		repeat (3) @(posedge clock_in);
		check("timer sel", timer_sel, 1'b1);
		pulse(1'b0);
		rchk("no alternation", 32'hb4, 32'h08);
		bus(1'b1, 32'hb4, 32'hc0);
		rchk("flop not writable", 32'hb4, 32'h80);
		pulse(1'b0);
		rchk("flop set", 32'hb4, 32'hc0);
		pulse(1'b1);
		rchk("flop cleared", 32'hb4, 32'h80);
		pulse(1'b0);
		bus(1'b1, 32'hb4, 32'h00);
		rchk("flop forced off", 32'hb4, 32'h00);
		bus(1'b1, 32'h100, 32'h02);
		rchk("main set", 32'h100, 32'h06);
		// Each route code 000 to 011 in both directions, only its own source raised.
		for (int i = 0; i < 8; i++) begin
			bus(1'b1, 32'hc8, {24'h0, 6'h3c, i[2], 1'b0});
			bus(1'b1, 32'hb4, {30'h0, i[1:0]});
			slow <= i[2];
			want <= (i[1:0] == 2'h0) ? 6'h02 : (i[1:0] == 2'h3) ? 6'h01 :
				6'(6'h04 << {i[1], i[2]});
			watch(40);
			check("routed", {h != 0, req.to_ch1, req.source}, {2'b11, 1'b0, i[1:0]});
			want <= 6'h00;
			watch(40);
			check("drained", req_valid, 1'b0);
		end
		bus(1'b1, 32'hb4, 32'h04);
		want <= 6'h3f;
		watch(40);
		check("reserved route quiet", h, 0);
		bus(1'b1, 32'hb4, 32'h00);
		want <= 6'h00;
		watch(40);
		@(posedge clock_in);
		nmi <= 1'b1;
		@(posedge clock_in);
		nmi <= 1'b0;
		rchk("nmi clears main", 32'h100, 32'h02);
		want <= 6'h02;
		watch(40);
		check("halted quiet", h, 0);
		// Channel 0 timed by its pin: one request per rising edge, then a stream.
		slow <= 1'b0;
		want <= 6'h00;
		bus(1'b1, 32'hc4, 32'h0c);
		bus(1'b1, 32'hc8, 32'h04);
		bus(1'b1, 32'h100, 32'h01);
		want <= 6'h01;
		watch(40);
		check("edge once", h0, 1);
		bus(1'b1, 32'hc8, 32'h00);
		watch(40);
		check("level stream", h0 > 1, 1'b1);
		// Stepping memory to memory needs no pin; the mode bit asks for burst.
		bus(1'b1, 32'hc4, 32'h02);
		watch(20);
		check("burst tag", {h0 > 1, req.to_ch1, req.burst}, 3'b101);
		// Fixed to fixed stays silent once the queue has drained.
		bus(1'b1, 32'hc4, 32'h3c);
		watch(20);
		watch(40);
		check("reserved ch0 quiet", h0, 0);
		complete_run();
	end

	// The tests need well under 20000 cycles.
	initial begin
		#(20 * 20000);
		miscompares++;
		complete_run();
	end
endmodule

// File: dv/dmarr_src_model.sv
module dmarr_src_model (
	// Clock and the levels the bench wants on the request lines.
	input  wire logic       clock_in,
	input  wire logic [5:0] want_in,
	input  wire logic       slow_in,
	// Request lines and the engine handshake.
	output logic      [5:0] pins_out,
	output logic            engine_ready_out
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [5:0] pins_reg  = 6'h00;
	logic [1:0] beat_reg  = 2'h0;
	logic       ready_reg = 1'b1;

	// Sources move just after an edge, as synchronous requesters do.
	// A slow engine takes one beat in four, so the queue really backs up.
	always @(posedge clock_in) begin
		pins_reg  <= want_in;
		beat_reg  <= beat_reg + 2'h1;
		ready_reg <= !slow_in || (beat_reg == 2'h0);
	end

	assign pins_out         = pins_reg;
	assign engine_ready_out = ready_reg;
endmodule

// File: verilog/dmarr_fifo.sv
module dmarr_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// Clock and reset.
	input  wire logic             clock_in,
	input  wire logic             rst_b_in,
	// Fill side.
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	// Drain side.
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic      [WIDTH-1:0] out_data_out
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	logic             push;
	logic             pop;

	// ==========================================================
	// Handshakes.
	// ==========================================================
	// Ready and valid follow the count only, so both are honest.
	assign in_ready_out  = (count_reg != (AW+1)'(DEPTH));
	assign out_valid_out = (count_reg != '0);
	assign push          = in_valid_in && in_ready_out;
	assign pop           = out_valid_out && out_ready_in;
	assign out_data_out  = mem[rd_ptr_reg];

	// Storage is written without reset; only the pointers matter.
	always_ff @(posedge clock_in) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data_in;
		end
	end

	// Pointers wrap at the depth.
	always_ff @(posedge clock_in) begin
		if (!rst_b_in) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
			end
		end
	end

	// Occupancy count.
	always_ff @(posedge clock_in) begin
		if (!rst_b_in) begin
			count_reg <= '0;
		end else if (push && !pop) begin
			count_reg <= count_reg + 1'b1;
		end else if (pop && !push) begin
			count_reg <= count_reg - 1'b1;
		end
	end
endmodule

// File: verilog/dmarr_pkg.sv
package dmarr_pkg;

	// ==========================================================
	// Register map (byte addresses are four times the index).
	// ==========================================================
	localparam logic [7:0]  ROUTE_IDX       = 8'h2d;
	localparam logic [7:0]  WAIT_IDX        = 8'h32;
	localparam logic [7:0]  CH0_MODE_IDX    = 8'h31;
	localparam logic [7:0]  ENABLE_IDX      = 8'h40;
	localparam logic [7:0]  STATUS_IDX      = 8'h41;
	localparam logic [7:0]  WAIT_RESET      = 8'hf0;
	localparam logic [7:0]  ROUTE_RESET     = 8'h00;
	localparam logic [7:0]  CH0_MODE_RESET  = 8'h00;

	// ==========================================================
	// Field positions.
	// ==========================================================
	localparam int ROUTE_ALT_EN_BIT  = 7;
	localparam int ROUTE_ALT_FF_BIT  = 6;
	localparam int ROUTE_TIMER_BIT   = 3;
	localparam int CH1_DIR_BIT       = 1;

	// ==========================================================
	// Addressing modes of a channel 0 mode field.
	// ==========================================================
	localparam logic [1:0] MODE_MEM_INC   = 2'h0;
	localparam logic [1:0] MODE_MEM_DEC   = 2'h1;
	localparam logic [1:0] MODE_MEM_FIXED = 2'h2;
	localparam logic [1:0] MODE_IO_FIXED  = 2'h3;

	// Channel 1 request route codes.
	localparam logic [2:0] ROUTE_EXT_CH1  = 3'h0;
	localparam logic [2:0] ROUTE_SERIAL0  = 3'h1;
	localparam logic [2:0] ROUTE_SERIAL1  = 3'h2;
	localparam logic [2:0] ROUTE_CH0_PIN  = 3'h3;

	// Shared control register view.
	typedef struct packed {
		logic [1:0] memory_wait_count;
		logic [1:0] io_wait_count;
		logic [1:0] request_sense_select;
		logic [1:0] ch1_transfer_mode;
	} dmarr_wait_t;

	// Decoded per-channel addressing.
	typedef struct packed {
		logic       src_io;
		logic       src_mem_cycle;
		logic [1:0] src_step;
		logic       dst_io;
		logic       dst_mem_cycle;
		logic [1:0] dst_step;
		logic       valid;
	} dmarr_chan_t;

	// Address step codes: 0 hold, 1 increment, 2 decrement.
	localparam logic [1:0] STEP_HOLD = 2'h0;
	localparam logic [1:0] STEP_INC  = 2'h1;
	localparam logic [1:0] STEP_DEC  = 2'h2;

	// Request to the transfer engine with its routing tag.
	typedef struct packed {
		logic       to_ch1;
		logic       burst;
		logic [2:0] source;
	} dmarr_req_t;

	localparam int REQ_W = 5;

endpackage

// File: verilog/dmarr_top.sv
module dmarr_top
#(
	parameter int FIFO_DEPTH = 4
) (
	// Clock and reset.
	input  wire logic                clock_in,
	input  wire logic                rst_b_in,
	// AHB-Lite slave.
	input  wire logic                hsel_in,
	input  wire logic [31:0]         haddr_in,
	input  wire logic [1:0]          htrans_in,
	input  wire logic                hwrite_in,
	input  wire logic [2:0]          hsize_in,
	input  wire logic [31:0]         hwdata_in,
	input  wire logic                hready_in,
	output logic      [31:0]         hrdata_out,
	output logic                     hreadyout_out,
	output logic                     hresp_out,
	// Request sources, active high, synchronous.
	input  wire logic                ch0_request_pin_in,
	input  wire logic                ch1_request_pin_in,
	input  wire logic                serial0_tx_req_in,
	input  wire logic                serial0_rx_req_in,
	input  wire logic                serial1_tx_req_in,
	input  wire logic                serial1_rx_req_in,
	input  wire logic                nmi_in,
	// Transfer engine handshake.
	input  wire logic                ch0_transfer_end_in,
	input  wire logic                ch1_transfer_end_in,
	input  wire logic                engine_ready_in,
	output logic                     req_valid_out,
	output dmarr_pkg::dmarr_req_t    req_out,
	// Decoded configuration.
	output dmarr_pkg::dmarr_wait_t   wait_cfg_out,
	output dmarr_pkg::dmarr_chan_t   ch0_cfg_out,
	output dmarr_pkg::dmarr_chan_t   ch1_cfg_out,
	output logic                     timer_output_sel_out
);
	import dmarr_pkg::*;

	// ==========================================================
	// Decode functions.
	// ==========================================================
	// Step code of a two-bit channel 0 mode field.
	function automatic logic [1:0] mode_step(input logic [1:0] m);
		case (m)
			MODE_MEM_INC: mode_step = STEP_INC;
			MODE_MEM_DEC: mode_step = STEP_DEC;
			default:      mode_step = STEP_HOLD;
		endcase
	endfunction

	// A fixed field is 10 or 11, which is the top bit set.
	function automatic logic mode_fixed(input logic [1:0] m);
		mode_fixed = m[1];
	endfunction

	// Word index of an AHB byte address.
	function automatic logic [7:0] word_idx(input logic [31:0] a);
		word_idx = a[9:2];
	endfunction

	// ==========================================================
	// Registers.
	// ==========================================================
	logic [7:0]  route_reg;
	dmarr_wait_t wait_reg;
	logic [7:0]  ch0_mode_reg;
	logic [1:0]  chan_en_reg;
	logic        main_en_reg;
	logic        alt_ff;
	logic        wr_pend_reg;
	logic [7:0]  wr_idx_reg;
	logic [1:0]  prev_req_reg;
	logic [1:0]  dst_mode;
	logic [1:0]  src_mode;
	logic        ch0_valid;
	logic        ch1_valid;
	logic [2:0]  route_code;
	logic        ch1_dir;
	logic        ch1_raw;
	logic        shared_req;
	logic [1:0]  level_req;
	logic [1:0]  sensed_req;
	logic [1:0]  run_req;
	logic        addr_ok;
	logic        fifo_ready;
	dmarr_req_t  push_data;
	logic        push_valid;
	logic        fifo_valid;
	dmarr_req_t  fifo_data;
	logic [31:0] rd_mux;

	assign dst_mode   = ch0_mode_reg[5:4];
	assign src_mode   = ch0_mode_reg[3:2];
	assign route_code = route_reg[2:0];
	assign ch1_dir    = wait_reg.ch1_transfer_mode[CH1_DIR_BIT];

	// ==========================================================
	// Bus slave.
	// ==========================================================
	// Address phase is captured; data phase completes with zero waits.
	assign addr_ok = hsel_in && hready_in && htrans_in[1];

	always_ff @(posedge clock_in) begin
		if (!rst_b_in) begin
			wr_pend_reg <= 1'b0;
			wr_idx_reg  <= 8'h00;
		end else begin
			wr_pend_reg <= addr_ok && hwrite_in;
			if (addr_ok) begin
				wr_idx_reg <= word_idx(haddr_in);
			end
		end
	end

	// Read data is registered at the address phase so it sits in a flop.
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (word_idx(haddr_in))
			ROUTE_IDX:    rd_mux[7:0] = {route_reg[7], alt_ff, route_reg[5:0]};
			WAIT_IDX:     rd_mux[7:0] = wait_reg;
			CH0_MODE_IDX: rd_mux[7:0] = ch0_mode_reg;
			ENABLE_IDX:   rd_mux[2:0] = {main_en_reg, chan_en_reg};
			STATUS_IDX:   rd_mux[1:0] = {ch1_valid, ch0_valid};
			default:      rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clock_in) begin
		if (!rst_b_in) begin
			hrdata_out <= 32'h0000_0000;
		end else if (addr_ok && !hwrite_in) begin
			hrdata_out <= rd_mux;
		end
	end

	// Always ready and OKAY; unmapped reads return zero.
	always_ff @(posedge clock_in) begin
		if (!rst_b_in) begin
			hreadyout_out <= 1'b1;
			hresp_out     <= 1'b0;
		end else begin
			hreadyout_out <= 1'b1;
			hresp_out     <= 1'b0;
		end
	end

	// Shared wait and channel 1 mode register.
	always_ff @(posedge clock_in) begin
		if (!rst_b_in) begin
			wait_reg <= WAIT_RESET;
		end else if (wr_pend_reg && wr_idx_reg == WAIT_IDX) begin
			wait_reg <= hwdata_in[7:0];
		end
	end

	// Channel 0 mode register; unused bits stay zero.
	always_ff @(posedge clock_in) begin
		if (!rst_b_in) begin
			ch0_mode_reg <= CH0_MODE_RESET;
		end else if (wr_pend_reg && wr_idx_reg == CH0_MODE_IDX) begin
			ch0_mode_reg <= {2'b00, hwdata_in[5:1], 1'b0};
		end
	end

	// Routing register; bit 6 lives in the alternation flop instead.
	always_ff @(posedge clock_in) begin
		if (!rst_b_in) begin
			route_reg <= ROUTE_RESET;
		end else if (wr_pend_reg && wr_idx_reg == ROUTE_IDX) begin
			route_reg <= {hwdata_in[7], 1'b0, hwdata_in[5:0]};
		end
	end

	// Channel and main enables; writing a channel enable sets main again.
	always_ff @(posedge clock_in) begin
		if (!rst_b_in) begin
			chan_en_reg <= 2'b00;
			main_en_reg <= 1'b0;
		end else begin
			if (wr_pend_reg && wr_idx_reg == ENABLE_IDX) begin
				chan_en_reg <= hwdata_in[1:0];
			end
			if (nmi_in) begin
				main_en_reg <= 1'b0;
			end else if (wr_pend_reg && wr_idx_reg == ENABLE_IDX && |hwdata_in[1:0]) begin
				main_en_reg <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Alternation flop.
	// ==========================================================
	// Channel 0 end wins if both ends land together, so no request is lost.
	always_ff @(posedge clock_in) begin
		if (!rst_b_in) begin
			alt_ff <= 1'b0;
		end else if (!route_reg[ROUTE_ALT_EN_BIT]) begin
			alt_ff <= 1'b0;
		end else if (ch0_transfer_end_in) begin
			alt_ff <= 1'b1;
		end else if (ch1_transfer_end_in) begin
			alt_ff <= 1'b0;
		end
	end

	// ==========================================================
	// Mode validity and request routing.
	// ==========================================================
	// Two fixed fields together are reserved, covering I/O to I/O.
	assign ch0_valid = !(mode_fixed(dst_mode) && mode_fixed(src_mode));

	// Only codes 000 to 011 route a request to channel 1.
	assign ch1_valid = !route_code[2];

	always_comb begin
		case (route_code)
			ROUTE_EXT_CH1: ch1_raw = ch1_request_pin_in;
			ROUTE_SERIAL0: ch1_raw = ch1_dir ? serial0_rx_req_in : serial0_tx_req_in;
			ROUTE_SERIAL1: ch1_raw = ch1_dir ? serial1_rx_req_in : serial1_tx_req_in;
			ROUTE_CH0_PIN: ch1_raw = ch0_request_pin_in;
			default:       ch1_raw = 1'b0;
		endcase
	end

	// The shared pin feeds channel 0 unless the flop has moved it over.
	// When sources differ, channel 0's pin is what is forced to channel 1.
	assign shared_req = ch0_request_pin_in;

	always_comb begin
		if (route_reg[ROUTE_ALT_EN_BIT]) begin
			level_req[0] = alt_ff ? 1'b0 : shared_req;
			level_req[1] = alt_ff ? shared_req : 1'b0;
		end else begin
			level_req[0] = ch0_request_pin_in;
			level_req[1] = ch1_raw;
		end
	end

	// Edge sense fires once per rising request; level sense follows it.
	always_ff @(posedge clock_in) begin
		if (!rst_b_in) begin
			prev_req_reg <= 2'b00;
		end else begin
			prev_req_reg <= level_req;
		end
	end

	for (genvar c = 0; c < 2; c++) begin : g_sense
		assign sensed_req[c] = wait_reg.request_sense_select[c] ?
		                       (level_req[c] && !prev_req_reg[c]) : level_req[c];
	end

	// Memory-to-memory on channel 0 with neither field fixed runs on its own; no pin is needed.
	assign run_req[0] = chan_en_reg[0] && main_en_reg && ch0_valid &&
	                    (ch0_cfg_out.src_io || ch0_cfg_out.dst_io ||
	                     (mode_fixed(dst_mode) || mode_fixed(src_mode)) ?
	                     sensed_req[0] : 1'b1);
	assign run_req[1] = chan_en_reg[1] && main_en_reg && ch1_valid &&
	                    sensed_req[1];

	// Channel 0 has priority at the FIFO entry.
	always_comb begin
		push_data        = '0;
		push_valid       = |run_req;
		push_data.to_ch1 = !run_req[0];
		push_data.burst  = run_req[0] && ch0_mode_reg[1];
		push_data.source = run_req[0] ? 3'h0 : route_code;
	end

	dmarr_fifo #(
		.WIDTH (REQ_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clock_in      (clock_in),
		.rst_b_in      (rst_b_in),
		.in_valid_in   (push_valid),
		.in_ready_out  (fifo_ready),
		.in_data_in    (push_data),
		.out_valid_out (fifo_valid),
		.out_ready_in  (engine_ready_in && !req_valid_out),
		.out_data_out  (fifo_data)
	);

	// Output stage holds a request until the engine takes it.
	always_ff @(posedge clock_in) begin
		if (!rst_b_in) begin
			req_valid_out <= 1'b0;
			req_out       <= '0;
		end else if (req_valid_out && engine_ready_in) begin
			req_valid_out <= 1'b0;
		end else if (!req_valid_out && fifo_valid && engine_ready_in) begin
			req_valid_out <= 1'b1;
			req_out       <= fifo_data;
		end
	end

	// ==========================================================
	// Decoded configuration outputs.
	// ==========================================================
	always_ff @(posedge clock_in) begin
		if (!rst_b_in) begin
			ch0_cfg_out          <= '0;
			ch1_cfg_out          <= '0;
			wait_cfg_out         <= WAIT_RESET;
			timer_output_sel_out <= 1'b0;
		end else begin
			wait_cfg_out               <= wait_reg;
			timer_output_sel_out       <= route_reg[ROUTE_TIMER_BIT];
			ch0_cfg_out.src_io         <= (src_mode == MODE_IO_FIXED);
			ch0_cfg_out.src_mem_cycle  <= (src_mode != MODE_IO_FIXED);
			ch0_cfg_out.src_step       <= mode_step(src_mode);
			ch0_cfg_out.dst_io         <= (dst_mode == MODE_IO_FIXED);
			ch0_cfg_out.dst_mem_cycle  <= (dst_mode != MODE_IO_FIXED);
			ch0_cfg_out.dst_step       <= mode_step(dst_mode);
			ch0_cfg_out.valid          <= ch0_valid;
			ch1_cfg_out.src_io         <= ch1_dir;
			ch1_cfg_out.src_mem_cycle  <= !ch1_dir;
			ch1_cfg_out.src_step       <= ch1_dir ? STEP_HOLD :
			                              (wait_reg.ch1_transfer_mode[0] ? STEP_DEC : STEP_INC);
			ch1_cfg_out.dst_io         <= !ch1_dir;
			ch1_cfg_out.dst_mem_cycle  <= ch1_dir;
			ch1_cfg_out.dst_step       <= !ch1_dir ? STEP_HOLD :
			                              (wait_reg.ch1_transfer_mode[0] ? STEP_DEC : STEP_INC);
			ch1_cfg_out.valid          <= ch1_valid;
		end
	end

	// ==========================================================
	// Checks.
	// ==========================================================
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rst_b_in);

	chk_alt_set_end: assert property (
		route_reg[ROUTE_ALT_EN_BIT] && ch0_transfer_end_in |=> alt_ff)
		else $error("Channel 0 end did not set alternation flop.");
	chk_alt_clear_end: assert property (
		route_reg[ROUTE_ALT_EN_BIT] && !ch0_transfer_end_in && ch1_transfer_end_in |=> !alt_ff)
		else $error("Channel 1 end did not clear alternation flop.");
	chk_alt_idle_zero: assert property (
		!route_reg[ROUTE_ALT_EN_BIT] |=> !alt_ff)
		else $error("Alternation flop set while independent.");
	chk_alt_route_ch1: assert property (
		route_reg[ROUTE_ALT_EN_BIT] && alt_ff |-> !level_req[0] && level_req[1] == shared_req)
		else $error("Shared request not moved to channel 1.");
	chk_reserved_quiet: assert property (
		!ch0_valid |-> !run_req[0])
		else $error("Reserved channel 0 mode raised a request.");
	chk_route_quiet: assert property (
		route_code[2] && !route_reg[ROUTE_ALT_EN_BIT] |-> !run_req[1])
		else $error("Reserved route code raised a request.");
	chk_nmi_main_off: assert property (
		nmi_in |=> !main_en_reg ##0 !run_req[0] && !run_req[1])
		else $error("NMI did not stop transfers.");
	chk_timer_sel: assert property (
		wr_pend_reg && wr_idx_reg == ROUTE_IDX |=> ##1 timer_output_sel_out == $past(hwdata_in[3], 2))
		else $error("Timer select did not follow write.");
	chk_wait_write: assert property (
		wr_pend_reg && wr_idx_reg == WAIT_IDX |=> wait_reg[7:6] == $past(hwdata_in[7:6]))
		else $error("Memory wait field not written.");

	cov_alt_cycle: cover property (alt_ff ##[1:50] !alt_ff);
	cov_fifo_full: cover property (!fifo_ready);
	cov_edge_req: cover property (wait_reg.request_sense_select[0] && run_req[0]);
	cov_serial_rx: cover property (ch1_dir && route_code == ROUTE_SERIAL1 && run_req[1]);
endmodule
